// >>> core/hspx_pkg.sv
package hspx_pkg;

  // ************************************************************
  // configuration space map (byte offsets of the two dwords and of bytes inside them)
  // ************************************************************
  localparam logic [7:0] PM_DWORD_OFFSET = 8'hE0;
  localparam logic [7:0] HS_DWORD_OFFSET = 8'hE4;
  localparam logic [7:0] BRIDGE_PM_SUPPORT_EXT_OFFSET = 8'hE2;
  localparam logic [7:0] PM_DATA_BYTE_OFFSET = 8'hE3;
  localparam logic [7:0] HOTSWAP_CAP_IDENTIFIER_OFFSET = 8'hE4;
  localparam logic [7:0] HOTSWAP_NEXT_POINTER_OFFSET = 8'hE5;
  localparam logic [7:0] HOTSWAP_CONTROL_STATUS_OFFSET = 8'hE6;

  // ************************************************************
  // field positions inside the dwords
  // ************************************************************
  localparam int POWER_STATE_FIELD_LSB = 0;
  localparam int CLOCK_STOP_BIT = 22;
  localparam int BPCC_ENABLE_BIT = 23;
  localparam int PM_DATA_LSB = 24;
  localparam int CAP_ID_LSB = 0;
  localparam int NEXT_PTR_LSB = 8;
  localparam int DHA_BIT = 16;
  localparam int EIM_BIT = 17;
  localparam int PIE_BIT = 18;
  localparam int LED_BIT = 19;
  localparam int PI_LSB = 20;
  localparam int EXT_BIT = 22;
  localparam int INS_BIT = 23;

  // ************************************************************
  // constant and reset values
  // ************************************************************
  localparam logic [7:0] HOTSWAP_CAP_ID_VALUE = 8'h06;
  localparam logic [7:0] HOTSWAP_NEXT_PTR_VALUE = 8'h00;
  localparam logic [7:0] PM_DATA_VALUE = 8'h00;
  localparam logic [1:0] PROG_IFACE_VALUE = 2'h1;
  localparam logic [1:0] PWR_D0 = 2'h0;
  localparam logic [1:0] PWR_D3 = 2'h3;
  localparam logic [1:0] PWR_RESET = 2'h0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ************************************************************
  // hot-swap sequencer states
  // ************************************************************
  typedef enum logic [4:0] {
    HS_PROBE = 5'h01,
    HS_OPEN = 5'h02,
    HS_INSERT = 5'h04,
    HS_RUN = 5'h08,
    HS_EXTRACT = 5'h10
  } hspx_hs_state_type;

endpackage : hspx_pkg

// >>> core/hspx_regs.sv
`timescale 1ns/10ps
`default_nettype none

module hspx_regs (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cfg_req_i,
  input wire logic cfg_we_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_n_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic cfg_ack_o,
  output logic [31:0] cfg_rdata_o,
  input wire logic power_clock_ctrl_strap_i,
  input wire logic ejector_closed_i,
  output logic bus_respond_en_o,
  output logic hot_swap_enumeration_n_o,
  output logic hot_swap_enumeration_oe_o,
  output logic led_on_o,
  output logic sec_clock_stop_o,
  output logic chip_reset_o
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic strap_sync;
  logic handle_closed;

  hspx_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .clk_i(clk_i),
    .async_i({power_clock_ctrl_strap_i, ejector_closed_i}),
    .sync_o({strap_sync, handle_closed})
  );

  // ************************************************************
  // address decode
  // ************************************************************
  function automatic logic dword_hit(input logic [7:0] addr, input logic [7:0] base);
    dword_hit = (addr[7:2] == base[7:2]);
  endfunction : dword_hit

  logic device_hiding_arm;
  logic next_device_hiding_arm;
  logic enumeration_mask;
  logic next_enumeration_mask;
  logic led_control;
  logic next_led_control;
  logic removal_flag;
  logic next_removal_flag;
  logic board_added_flag;
  logic next_board_added_flag;
  hspx_pkg::hspx_hs_state_type hs_state;
  hspx_pkg::hspx_hs_state_type next_hs_state;
  logic [1:0] power_state_field;
  logic [1:0] next_power_state_field;
  logic chip_reset;
  logic next_chip_reset;
  logic cfg_ack;
  logic next_cfg_ack;
  logic [31:0] cfg_rdata;
  logic [31:0] next_cfg_rdata;
  logic ack_pm;
  logic next_ack_pm;

  logic hit_pm;
  logic hit_hs;
  logic take;
  logic wr_pm;
  logic wr_hs_lane2;
  logic bus_power_clock_ctrl_enable;
  logic clock_stop_in_d3hot;
  logic [31:0] pm_dword;
  logic [31:0] hs_dword;

  // hidden bridge claims nothing, so no write or read lands here
  assign hit_pm = dword_hit(cfg_addr_i, hspx_pkg::PM_DWORD_OFFSET);
  assign hit_hs = dword_hit(cfg_addr_i, hspx_pkg::HS_DWORD_OFFSET);
  assign take = cfg_req_i && !device_hiding_arm && (hit_pm || hit_hs);
  assign wr_pm = take && cfg_we_i && hit_pm && !cfg_be_n_i[0];
  assign wr_hs_lane2 = take && cfg_we_i && hit_hs && !cfg_be_n_i[2];

  // ************************************************************
  // read data assembly
  // ************************************************************
  // strap is live; clock-stop support is only meaningful with enable set
  assign bus_power_clock_ctrl_enable = strap_sync;
  assign clock_stop_in_d3hot = bus_power_clock_ctrl_enable;

  always_comb begin
    pm_dword = hspx_pkg::READ_ZERO;
    pm_dword[hspx_pkg::POWER_STATE_FIELD_LSB +: 2] = power_state_field;
    pm_dword[hspx_pkg::CLOCK_STOP_BIT] = clock_stop_in_d3hot;
    pm_dword[hspx_pkg::BPCC_ENABLE_BIT] = bus_power_clock_ctrl_enable;
    pm_dword[hspx_pkg::PM_DATA_LSB +: 8] = hspx_pkg::PM_DATA_VALUE;
  end

  always_comb begin
    hs_dword = hspx_pkg::READ_ZERO;
    hs_dword[hspx_pkg::CAP_ID_LSB +: 8] = hspx_pkg::HOTSWAP_CAP_ID_VALUE;
    hs_dword[hspx_pkg::NEXT_PTR_LSB +: 8] = hspx_pkg::HOTSWAP_NEXT_PTR_VALUE;
    hs_dword[hspx_pkg::DHA_BIT] = device_hiding_arm;
    hs_dword[hspx_pkg::EIM_BIT] = enumeration_mask;
    hs_dword[hspx_pkg::PIE_BIT] = 1'b0;
    hs_dword[hspx_pkg::LED_BIT] = led_control;
    hs_dword[hspx_pkg::PI_LSB +: 2] = hspx_pkg::PROG_IFACE_VALUE;
    hs_dword[hspx_pkg::EXT_BIT] = removal_flag;
    hs_dword[hspx_pkg::INS_BIT] = board_added_flag;
  end

  // ************************************************************
  // configuration response
  // ************************************************************
  // answer one cycle after the request; read data held until next read
  always_comb begin
    next_cfg_ack = take;
    next_ack_pm = take && hit_pm && !cfg_we_i; // marks a read of the power dword
    next_cfg_rdata = cfg_rdata;
    if (take && !cfg_we_i) begin
      next_cfg_rdata = hit_pm ? pm_dword : hs_dword;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_ack <= 1'b0;
      ack_pm <= 1'b0;
      cfg_rdata <= hspx_pkg::READ_ZERO;
    end else begin
      cfg_ack <= next_cfg_ack;
      ack_pm <= next_ack_pm;
      cfg_rdata <= next_cfg_rdata;
    end
  end

  // ************************************************************
  // power state
  // ************************************************************
  // unimplemented D1/D2 writes complete but leave the field alone
  always_comb begin
    next_power_state_field = power_state_field;
    next_chip_reset = 1'b0;
    if (wr_pm) begin
      if (cfg_wdata_i[1:0] == hspx_pkg::PWR_D0 || cfg_wdata_i[1:0] == hspx_pkg::PWR_D3) begin
        next_power_state_field = cfg_wdata_i[1:0];
      end
      if (power_state_field == hspx_pkg::PWR_D3 && cfg_wdata_i[1:0] == hspx_pkg::PWR_D0) begin
        next_chip_reset = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      power_state_field <= hspx_pkg::PWR_RESET;
      chip_reset <= 1'b0;
    end else begin
      power_state_field <= next_power_state_field;
      chip_reset <= next_chip_reset;
    end
  end

  // ************************************************************
  // hot-swap sequencer and control/status
  // ************************************************************
  // hardware events are applied after the software write so they beat
  // a software write landing in the same cycle
  always_comb begin
    next_hs_state = hs_state;
    next_device_hiding_arm = device_hiding_arm;
    next_enumeration_mask = enumeration_mask;
    next_led_control = led_control;
    next_removal_flag = removal_flag;
    next_board_added_flag = board_added_flag;
    if (wr_hs_lane2) begin
      next_device_hiding_arm = cfg_wdata_i[hspx_pkg::DHA_BIT];
      next_enumeration_mask = cfg_wdata_i[hspx_pkg::EIM_BIT];
      next_led_control = cfg_wdata_i[hspx_pkg::LED_BIT];
      if (cfg_wdata_i[hspx_pkg::EXT_BIT]) begin
        next_removal_flag = 1'b0;
      end
      if (cfg_wdata_i[hspx_pkg::INS_BIT]) begin
        next_board_added_flag = 1'b0;
      end
    end
    case (hs_state)
      hspx_pkg::HS_PROBE: begin
        if (handle_closed) begin
          next_hs_state = hspx_pkg::HS_INSERT;
        end else begin
          next_device_hiding_arm = 1'b1;
          next_hs_state = hspx_pkg::HS_OPEN;
        end
      end
      hspx_pkg::HS_OPEN: begin
        if (handle_closed) begin
          next_hs_state = hspx_pkg::HS_INSERT;
        end
      end
      hspx_pkg::HS_INSERT: begin
        next_board_added_flag = 1'b1;
        next_device_hiding_arm = 1'b0;
        next_hs_state = hspx_pkg::HS_RUN;
      end
      hspx_pkg::HS_RUN: begin
        if (!handle_closed) begin
          next_hs_state = hspx_pkg::HS_EXTRACT;
        end
      end
      hspx_pkg::HS_EXTRACT: begin
        next_removal_flag = 1'b1;
        next_hs_state = hspx_pkg::HS_OPEN;
      end
      default: begin
        next_hs_state = hspx_pkg::HS_PROBE;
      end
    endcase
  end

  // the probe state looks at the handle at the first edge after release
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hs_state <= hspx_pkg::HS_PROBE;
      device_hiding_arm <= 1'b0;
      enumeration_mask <= 1'b0;
      led_control <= 1'b0;
      removal_flag <= 1'b0;
      board_added_flag <= 1'b0;
    end else begin
      hs_state <= next_hs_state;
      device_hiding_arm <= next_device_hiding_arm;
      enumeration_mask <= next_enumeration_mask;
      led_control <= next_led_control;
      removal_flag <= next_removal_flag;
      board_added_flag <= next_board_added_flag;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // open-drain enumeration pin: only ever pulled low, all terms are flops
  assign hot_swap_enumeration_n_o = 1'b0;
  assign hot_swap_enumeration_oe_o = (board_added_flag || removal_flag) && !enumeration_mask;
  assign led_on_o = led_control;
  assign bus_respond_en_o = !device_hiding_arm;
  assign sec_clock_stop_o = bus_power_clock_ctrl_enable && (power_state_field == hspx_pkg::PWR_D3);
  assign chip_reset_o = chip_reset;
  assign cfg_ack_o = cfg_ack;
  assign cfg_rdata_o = cfg_rdata;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_clock_stop;
    @(posedge clk_i) disable iff (!rst_n_i)
    cfg_ack_o && ack_pm && cfg_rdata_o[23] |-> cfg_rdata_o[22];
  endproperty
  a_clock_stop: assert property (p_clock_stop) else $error("clock-stop bit not set");

  property p_strap;
    @(posedge clk_i) disable iff (!rst_n_i)
    cfg_req_i && !cfg_we_i && take && hit_pm |=> cfg_rdata_o[23] == $past(strap_sync);
  endproperty
  a_strap: assert property (p_strap) else $error("enable bit not following strap");

  property p_data_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
    cfg_ack_o && ack_pm |-> cfg_rdata_o[31:24] == 8'h00;
  endproperty
  a_data_zero: assert property (p_data_zero) else $error("data byte not zero");

  property p_hs_consts;
    @(posedge clk_i) disable iff (!rst_n_i)
    take && !cfg_we_i && hit_hs |=>
      cfg_rdata_o[15:0] == 16'h0006 && cfg_rdata_o[21:20] == 2'h1 && !cfg_rdata_o[18];
  endproperty
  a_hs_consts: assert property (p_hs_consts) else $error("hot-swap constants wrong");

  property p_hidden;
    @(posedge clk_i) disable iff (!rst_n_i)
    cfg_req_i && device_hiding_arm |=> !cfg_ack_o;
  endproperty
  a_hidden: assert property (p_hidden) else $error("hidden bridge answered");

  property p_arm_set;
    @(posedge clk_i) disable iff (!rst_n_i)
    hs_state == hspx_pkg::HS_PROBE && !handle_closed |=> device_hiding_arm;
  endproperty
  a_arm_set: assert property (p_arm_set) else $error("hiding not armed");

  property p_insert;
    @(posedge clk_i) disable iff (!rst_n_i)
    hs_state == hspx_pkg::HS_INSERT |=> !device_hiding_arm && board_added_flag;
  endproperty
  a_insert: assert property (p_insert) else $error("insertion state effects missing");

  property p_enum;
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_hs_lane2 |=>
      hot_swap_enumeration_oe_o == (!$past(cfg_wdata_i[17]) && (board_added_flag || removal_flag));
  endproperty
  a_enum: assert property (p_enum) else $error("enumeration drive wrong");

  property p_led;
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_hs_lane2 |=> led_on_o == $past(cfg_wdata_i[19]);
  endproperty
  a_led: assert property (p_led) else $error("led not following write");

  property p_ext_clear;
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_hs_lane2 && cfg_wdata_i[22] && hs_state != hspx_pkg::HS_EXTRACT |=> !removal_flag;
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("removal flag not cleared");

  property p_pwr_ignore;
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_pm && (cfg_wdata_i[1:0] == 2'h1 || cfg_wdata_i[1:0] == 2'h2) |=> $stable(power_state_field);
  endproperty
  a_pwr_ignore: assert property (p_pwr_ignore) else $error("bad power state taken");

  property p_chip_reset;
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_pm && power_state_field == 2'h3 && cfg_wdata_i[1:0] == 2'h0 |=> chip_reset_o ##1 !chip_reset_o;
  endproperty
  a_chip_reset: assert property (p_chip_reset) else $error("chip reset pulse missing");

endmodule : hspx_regs

`default_nettype wire

// >>> core/hspx_sync2.sv
`timescale 1ns/10ps
`default_nettype none

// two-stage synchroniser for pins and straps
module hspx_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // ************************************************************
  // elaboration check
  // ************************************************************
  if (WIDTH < 1) begin : g_bad_width
    $error("hspx_sync2 needs at least one bit");
  end

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  // first stage feeds only the second one; no reset, so the stages keep
  // sampling during reset and the pin level is through both when it ends
  always_ff @(posedge clk_i) begin
    stage1 <= async_i;
    stage2 <= stage1;
  end

  assign sync_o = stage2;

endmodule : hspx_sync2

`default_nettype wire

// >>> tb/hspx_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// primary bus host issuing configuration cycles
// ************************************************************
module hspx_host_model (
  input wire logic clk_i,
  input wire logic cfg_ack_i,
  input wire logic [31:0] cfg_rdata_i,
  output logic cfg_req_o,
  output logic cfg_we_o,
  output logic [7:0] cfg_addr_o,
  output logic [3:0] cfg_be_n_o,
  output logic [31:0] cfg_wdata_o
);
  // idle lines start at a defined level, never unknown
  initial begin
    cfg_req_o = 1'b0;
    cfg_we_o = 1'b0;
    cfg_addr_o = 8'h00;
    cfg_be_n_o = 4'hF;
    cfg_wdata_o = 32'h0000_0000;
  end

  // one access as a single-cycle pulse; gap idle cycles make a slow host
  // released lines carry the inverse so a stale value never looks valid
  task automatic xfer(input logic we, input logic [7:0] addr, input logic [3:0] be_n,
                      input logic [31:0] wd, input int gap, output logic got,
                      output logic [31:0] rd);
    int n;
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    cfg_req_o <= 1'b1;
    cfg_we_o <= we;
    cfg_addr_o <= addr;
    cfg_be_n_o <= be_n;
    cfg_wdata_o <= wd;
    // request is taken at this edge; the answer stands for the cycle after it
    @(posedge clk_i);
    cfg_req_o <= 1'b0;
    cfg_we_o <= ~we;
    cfg_addr_o <= ~addr;
    cfg_be_n_o <= ~be_n;
    cfg_wdata_o <= ~wd;
    got = 1'b0;
    rd = 32'h0000_0000;
    n = 0;
    #1;
    while (!got && n < 4) begin
      if (cfg_ack_i === 1'b1) begin
        got = 1'b1;
        rd = cfg_rdata_i;
      end else begin
        @(posedge clk_i);
        #1;
        n++;
      end
    end
  endtask : xfer
endmodule : hspx_host_model

`default_nettype wire

// >>> tb/tb_hot_swap_pm_ext_regs.sv
`timescale 1ns/10ps
`default_nettype none

module tb_hot_swap_pm_ext_regs;
  logic clk_i, rst_n_i, strap, ejector, req, we, ack, bus_en, enum_n, enum_oe, led, ckstop, crst;
  logic [7:0] addr;
  logic [3:0] be_n;
  logic [31:0] wdata, rdata, rd, r;
  logic got;
  logic [1:0] codes [8] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h0, 2'h3, 2'h0};
  int err_count, num_checks, seed, i, m_arm, m_mask, m_led, m_rem, m_ins, m_pwr, m_strap, m_crst;

  hspx_regs dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_req_i(req), .cfg_we_i(we),
    .cfg_addr_i(addr), .cfg_be_n_i(be_n), .cfg_wdata_i(wdata), .cfg_ack_o(ack),
    .cfg_rdata_o(rdata), .power_clock_ctrl_strap_i(strap), .ejector_closed_i(ejector),
    .bus_respond_en_o(bus_en), .hot_swap_enumeration_n_o(enum_n),
    .hot_swap_enumeration_oe_o(enum_oe), .led_on_o(led), .sec_clock_stop_o(ckstop),
    .chip_reset_o(crst));

  hspx_host_model host_u (.clk_i(clk_i), .cfg_ack_i(ack), .cfg_rdata_i(rdata),
    .cfg_req_o(req), .cfg_we_o(we), .cfg_addr_o(addr), .cfg_be_n_o(be_n),
    .cfg_wdata_o(wdata));

  // free-running 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // ************************************************************
  // reference model and checking helpers
  // ************************************************************
  function automatic logic [31:0] exp_hs();
    return {8'h00, m_ins[0], m_rem[0], hspx_pkg::PROG_IFACE_VALUE, m_led[0], 1'b0,
            m_mask[0], m_arm[0], 8'h00, 8'h06};
  endfunction : exp_hs

  function automatic logic [31:0] exp_pm();
    return {8'h00, m_strap[0], m_strap[0], 20'h0_0000, m_pwr[1:0]};
  endfunction : exp_pm

  function automatic logic [31:0] exp_oe();
    return {31'h0000_0000, (m_ins != 0 || m_rem != 0) && m_mask == 0};
  endfunction : exp_oe

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle

  // a refused read must never answer, so the ack itself is compared
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ea);
    r = $random(seed);
    host_u.xfer(1'b0, a, 4'h0, 32'h0000_0000, r[1:0], got, rd);
    chk({31'h0000_0000, got}, {31'h0000_0000, ea});
    if (ea) chk(rd, e);
  endtask : rd_chk

  // lane 2 write; the model only moves when the bridge is not hidden
  task automatic wr_hs(input logic [7:0] b);
    logic ea;
    ea = (m_arm == 0);
    host_u.xfer(1'b1, 8'hE4, 4'hB, {8'h00, b, 16'h0000}, 0, got, rd);
    chk({31'h0000_0000, got}, {31'h0000_0000, ea});
    if (ea) begin
      m_arm = b[0];
      m_mask = b[1];
      m_led = b[3];
      if (b[6]) m_rem = 0;
      if (b[7]) m_ins = 0;
    end
    chk({31'h0000_0000, enum_oe}, exp_oe());
    chk({31'h0000_0000, led}, m_led);
    chk({31'h0000_0000, bus_en}, m_arm == 0);
  endtask : wr_hs

  task automatic close_out();
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // watchdog: a hang counts as a failure
  initial begin
    #100000;
    err_count++;
    close_out();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    seed = 32'h984c;
    err_count = 0;
    num_checks = 0;
    rst_n_i = 1'b0;
    strap = 1'b0;
    ejector = 1'b0;
    {m_mask, m_led, m_rem, m_ins, m_pwr, m_strap} = '0;
    m_arm = 1;
    // two edges, enough for the pin synchronisers to carry the pin levels
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    settle(6);
    chk({31'h0000_0000, bus_en}, 32'h0000_0000);
    rd_chk(8'hE4, 32'h0000_0000, 1'b0);
    @(posedge clk_i);
    ejector <= 1'b1;
    settle(8);
    m_arm = 0;
    m_ins = 1;
    chk({31'h0000_0000, bus_en}, 32'h0000_0001);
    rd_chk(8'hE4, exp_hs(), 1'b1);
    chk({31'h0000_0000, enum_oe}, 32'h0000_0001);
    rd_chk(8'hE0, exp_pm(), 1'b1);
    @(posedge clk_i);
    strap <= 1'b1;
    m_strap = 1;
    settle(4);
    rd_chk(8'hE0, exp_pm(), 1'b1);
    wr_hs(8'h00);
    wr_hs(8'h02);
    wr_hs(8'h00);
    // random mask and led patterns with the insertion flag up
    for (i = 0; i < 6; i++) begin
      r = $random(seed);
      wr_hs(r[7:0] & 8'h0A);
      rd_chk(8'hE4, exp_hs(), 1'b1);
    end
    wr_hs(8'h80);
    // all lanes written: constant fields must not move
    host_u.xfer(1'b1, 8'hE4, 4'h0, 32'hFF34_FFFF, 0, got, rd);
    {m_arm, m_mask, m_led} = '0;
    rd_chk(8'hE4, exp_hs(), 1'b1);
    host_u.xfer(1'b1, 8'hE0, 4'h0, 32'hFFFF_FFFC, 0, got, rd);
    rd_chk(8'hE0, exp_pm(), 1'b1);
    rd_chk(8'hE8, 32'h0000_0000, 1'b0);
    rd_chk(8'hDC, 32'h0000_0000, 1'b0);
    // every power state code, unimplemented ones from both D0 and D3
    for (i = 0; i < 8; i++) begin
      m_crst = (m_pwr == 3 && codes[i] == 2'h0);
      if (codes[i] == 2'h0 || codes[i] == 2'h3) m_pwr = codes[i];
      host_u.xfer(1'b1, 8'hE0, 4'hE, {30'h0000_0000, codes[i]}, 0, got, rd);
      chk({31'h0000_0000, crst}, m_crst);
      chk({31'h0000_0000, ckstop}, m_pwr == 3 && m_strap == 1);
      rd_chk(8'hE0, exp_pm(), 1'b1);
    end
    @(posedge clk_i);
    ejector <= 1'b0;
    settle(8);
    m_rem = 1;
    chk({31'h0000_0000, enum_oe}, exp_oe());
    rd_chk(8'hE4, exp_hs(), 1'b1);
    wr_hs(8'h40);
    wr_hs(8'h01);
    rd_chk(8'hE4, 32'h0000_0000, 1'b0);
    wr_hs(8'h08);
    @(posedge clk_i);
    ejector <= 1'b1;
    settle(8);
    m_arm = 0;
    m_ins = 1;
    chk({31'h0000_0000, bus_en}, 32'h0000_0001);
    rd_chk(8'hE4, exp_hs(), 1'b1);
    chk({31'h0000_0000, enum_oe}, exp_oe());
    // second reset with the handle closed: no arming, straight to insertion
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    {m_arm, m_mask, m_led, m_rem, m_pwr} = '0;
    m_ins = 1;
    settle(4);
    chk({31'h0000_0000, bus_en}, 32'h0000_0001);
    chk({31'h0000_0000, enum_n}, 32'h0000_0000);
    chk({31'h0000_0000, enum_oe}, exp_oe());
    rd_chk(8'hE4, exp_hs(), 1'b1);
    rd_chk(8'hE0, exp_pm(), 1'b1);
    close_out();
  end
endmodule : tb_hot_swap_pm_ext_regs

`default_nettype wire
